// ==== src/gate_sel_regs.svh ====
`ifndef GATE_SEL_REGS_SVH
`define GATE_SEL_REGS_SVH

// ****************************************
// Register offsets (plain port, byte index)
// ****************************************
`define GATE1_SEL_OFS 4'h0
`define GATE2_SEL_OFS 4'h1
`define GATE3_SEL_OFS 4'h2
`define DATA_SRC_OFS 4'h3

// ****************************************
// Select bit positions within a gate register
// ****************************************
`define SEL_IN1_INV_BIT 0
`define SEL_IN1_TRUE_BIT 1
`define SEL_IN2_INV_BIT 2
`define SEL_IN2_TRUE_BIT 3
`define SEL_IN3_INV_BIT 4
`define SEL_IN3_TRUE_BIT 5
`define SEL_IN4_INV_BIT 6
`define SEL_IN4_TRUE_BIT 7

// ****************************************
// Data source select fields
// ****************************************
`define D3_SRC_LSB 0
`define D4_SRC_LSB 4
`define D4_SRC_BASE 4'h0
`define D4_WRAP_OFS 4'hc

// ****************************************
// Reset values; hardware leaves power-on content unknown
// ****************************************
`define GATE_SEL_RST 8'h00
`define D3_SRC_RST 3'h0
`define D4_SRC_RST 3'h0
`define RDATA_RST 8'h00

`endif

// ==== src/gate_sel_pkg.sv ====
package gate_sel_pkg;
  typedef logic [7:0] sel_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef struct packed {
    logic d4;
    logic d3;
    logic d2;
    logic d1;
  } data_in_s;
  typedef struct packed {
    logic g3;
    logic g2;
    logic g1;
  } gate_out_s;
endpackage

// ==== src/gate_mix.sv ====
`timescale 1ns/1ps
`include "gate_sel_regs.svh"
module gate_mix (
  input wire logic [7:0] i_sel,
  input wire gate_sel_pkg::data_in_s i_data,
  output logic o_gate
);
  import gate_sel_pkg::*;
  logic [7:0] cand;
  // ****************************************
  // Candidate signals
  // ****************************************
  // [RULE6] true and inverted copies
  assign cand[`SEL_IN1_INV_BIT] = ~i_data.d1;
  assign cand[`SEL_IN1_TRUE_BIT] = i_data.d1;
  assign cand[`SEL_IN2_INV_BIT] = ~i_data.d2;
  assign cand[`SEL_IN2_TRUE_BIT] = i_data.d2;
  assign cand[`SEL_IN3_INV_BIT] = ~i_data.d3;
  assign cand[`SEL_IN3_TRUE_BIT] = i_data.d3;
  assign cand[`SEL_IN4_INV_BIT] = ~i_data.d4;
  assign cand[`SEL_IN4_TRUE_BIT] = i_data.d4;
  // [RULE4] enabled candidates are ORed in
  assign o_gate = |(cand & i_sel);
endmodule // gate_mix

// ==== src/logic_cell_gate_input_select.sv ====
`timescale 1ns/1ps
`include "gate_sel_regs.svh"
// Notes on behaviour
// [RULE1] Gate 1 select bits 7..0 are data4 true/inv, data3, data2, data1 true/inv.
// [RULE2] Gate 2 select uses the same order, bit 0 inverted data1, bit 7 true data4.
// [RULE3] Gate 3 select uses the same order, bit 3 true data2, bit 2 inverted data2.
// [RULE4] A set select bit puts its signal into the gate, a clear bit keeps it out.
// [RULE5] All select bits are read/write and keep their value over non-power resets; here the only reset, i_nrst, clears them to zero.
// [RULE6] Each data input offers a true and an inverted copy, selectable per gate.
// [RULE7] Data 3 comes from source inputs 8..15 by a 3-bit code, 111 meaning 15.
// [RULE8] Data 4 comes from a 3-bit code where 011 means input 15 and 111 input 3.
// [RULE9] Select writes reach the gates combinationally with no extra step.
module logic_cell_gate_input_select (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire gate_sel_pkg::reg_req_s i_req,
  output logic [7:0] o_rdata,
  input wire logic [15:0] i_src,
  input wire logic i_d1,
  input wire logic i_d2,
  output gate_sel_pkg::gate_out_s o_gates,
  output gate_sel_pkg::data_in_s o_data
);
  import gate_sel_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  sel_t g1_sel_ff;
  sel_t g2_sel_ff;
  sel_t g3_sel_ff;
  logic [2:0] d3_src_ff;
  logic [2:0] d4_src_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic wr_g1;
  logic wr_g2;
  logic wr_g3;
  logic wr_src;
  logic rd_g1;
  logic rd_g2;
  logic rd_g3;
  logic rd_src;
  logic [7:0] src_word;
  logic [3:0] d3_idx;
  logic [3:0] d4_idx;
  data_in_s data;
  logic g1_out;
  logic g2_out;
  logic g3_out;
  sel_t g1_en;
  sel_t g2_en;
  sel_t g3_en;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  // [RULE5] write and read strobes
  assign wr_g1 = i_req.wr & hit(i_req.addr, `GATE1_SEL_OFS);
  assign wr_g2 = i_req.wr & hit(i_req.addr, `GATE2_SEL_OFS);
  assign wr_g3 = i_req.wr & hit(i_req.addr, `GATE3_SEL_OFS);
  assign wr_src = i_req.wr & hit(i_req.addr, `DATA_SRC_OFS);

  assign rd_g1 = i_req.rd & hit(i_req.addr, `GATE1_SEL_OFS);
  assign rd_g2 = i_req.rd & hit(i_req.addr, `GATE2_SEL_OFS);
  assign rd_g3 = i_req.rd & hit(i_req.addr, `GATE3_SEL_OFS);
  assign rd_src = i_req.rd & hit(i_req.addr, `DATA_SRC_OFS);

  // Content would be unknown on power-up; a fixed value keeps simulation clean.
  // [RULE5] writable selects
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      g1_sel_ff <= `GATE_SEL_RST;
      g2_sel_ff <= `GATE_SEL_RST;
      g3_sel_ff <= `GATE_SEL_RST;
    end else begin
      if (wr_g1) g1_sel_ff <= i_req.wdata;
      if (wr_g2) g2_sel_ff <= i_req.wdata;
      if (wr_g3) g3_sel_ff <= i_req.wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      d3_src_ff <= `D3_SRC_RST;
      d4_src_ff <= `D4_SRC_RST;
    end else if (wr_src) begin
      d3_src_ff <= i_req.wdata[`D3_SRC_LSB +: 3];
      d4_src_ff <= i_req.wdata[`D4_SRC_LSB +: 3];
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  // [RULE5] readable selects
  // Bits 7 and 3 of the source word hold nothing and read as zero
  assign src_word = {1'b0, d4_src_ff, 1'b0, d3_src_ff};
  assign nxt_rdata = rd_g1 ? g1_sel_ff :
                     rd_g2 ? g2_sel_ff :
                     rd_g3 ? g3_sel_ff :
                     rd_src ? src_word :
                     8'h00;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) rdata_ff <= `RDATA_RST;
    else rdata_ff <= nxt_rdata;
  end
  assign o_rdata = rdata_ff;

  // ****************************************
  // Data input sources
  // ****************************************
  // [RULE7] data3 from inputs 8..15
  assign d3_idx = {1'b1, d3_src_ff};
  // [RULE8] data4 codes 000..011 give 12..15, 100..111 give 0..3
  assign d4_idx = d4_src_ff[2] ? {2'b00, d4_src_ff[1:0]} : {2'b11, d4_src_ff[1:0]};
  assign data = '{d4: i_src[d4_idx], d3: i_src[d3_idx], d2: i_d2, d1: i_d1};
  assign o_data = data;

  // ****************************************
  // Gate 1 select bits
  // ****************************************
  // [RULE1] gate 1 bit map
  logic g1_in4_true_en;
  logic g1_in4_inv_en;
  logic g1_in3_true_en;
  logic g1_in3_inv_en;
  logic g1_in2_true_en;
  logic g1_in2_inv_en;
  logic g1_in1_true_en;
  logic g1_in1_inv_en;

  assign g1_in4_true_en = g1_sel_ff[`SEL_IN4_TRUE_BIT];
  assign g1_in4_inv_en = g1_sel_ff[`SEL_IN4_INV_BIT];
  assign g1_in3_true_en = g1_sel_ff[`SEL_IN3_TRUE_BIT];
  assign g1_in3_inv_en = g1_sel_ff[`SEL_IN3_INV_BIT];
  assign g1_in2_true_en = g1_sel_ff[`SEL_IN2_TRUE_BIT];
  assign g1_in2_inv_en = g1_sel_ff[`SEL_IN2_INV_BIT];
  assign g1_in1_true_en = g1_sel_ff[`SEL_IN1_TRUE_BIT];
  assign g1_in1_inv_en = g1_sel_ff[`SEL_IN1_INV_BIT];
  // Order must match the candidate order inside gate_mix
  assign g1_en = {g1_in4_true_en, g1_in4_inv_en, g1_in3_true_en, g1_in3_inv_en,
                  g1_in2_true_en, g1_in2_inv_en, g1_in1_true_en, g1_in1_inv_en};

  // ****************************************
  // Gate 2 select bits
  // ****************************************
  // [RULE2] gate 2 bit map
  logic g2_in4_true_en;
  logic g2_in4_inv_en;
  logic g2_in3_true_en;
  logic g2_in3_inv_en;
  logic g2_in2_true_en;
  logic g2_in2_inv_en;
  logic g2_in1_true_en;
  logic g2_in1_inv_en;

  assign g2_in4_true_en = g2_sel_ff[`SEL_IN4_TRUE_BIT];
  assign g2_in4_inv_en = g2_sel_ff[`SEL_IN4_INV_BIT];
  assign g2_in3_true_en = g2_sel_ff[`SEL_IN3_TRUE_BIT];
  assign g2_in3_inv_en = g2_sel_ff[`SEL_IN3_INV_BIT];
  assign g2_in2_true_en = g2_sel_ff[`SEL_IN2_TRUE_BIT];
  assign g2_in2_inv_en = g2_sel_ff[`SEL_IN2_INV_BIT];
  assign g2_in1_true_en = g2_sel_ff[`SEL_IN1_TRUE_BIT];
  assign g2_in1_inv_en = g2_sel_ff[`SEL_IN1_INV_BIT];
  assign g2_en = {g2_in4_true_en, g2_in4_inv_en, g2_in3_true_en, g2_in3_inv_en,
                  g2_in2_true_en, g2_in2_inv_en, g2_in1_true_en, g2_in1_inv_en};

  // ****************************************
  // Gate 3 select bits
  // ****************************************
  // [RULE3] gate 3 bit map
  logic g3_in4_true_en;
  logic g3_in4_inv_en;
  logic g3_in3_true_en;
  logic g3_in3_inv_en;
  logic g3_in2_true_en;
  logic g3_in2_inv_en;
  logic g3_in1_true_en;
  logic g3_in1_inv_en;

  assign g3_in4_true_en = g3_sel_ff[`SEL_IN4_TRUE_BIT];
  assign g3_in4_inv_en = g3_sel_ff[`SEL_IN4_INV_BIT];
  assign g3_in3_true_en = g3_sel_ff[`SEL_IN3_TRUE_BIT];
  assign g3_in3_inv_en = g3_sel_ff[`SEL_IN3_INV_BIT];
  assign g3_in2_true_en = g3_sel_ff[`SEL_IN2_TRUE_BIT];
  assign g3_in2_inv_en = g3_sel_ff[`SEL_IN2_INV_BIT];
  assign g3_in1_true_en = g3_sel_ff[`SEL_IN1_TRUE_BIT];
  assign g3_in1_inv_en = g3_sel_ff[`SEL_IN1_INV_BIT];
  assign g3_en = {g3_in4_true_en, g3_in4_inv_en, g3_in3_true_en, g3_in3_inv_en,
                  g3_in2_true_en, g3_in2_inv_en, g3_in1_true_en, g3_in1_inv_en};

  // ****************************************
  // Gate matrices
  // ****************************************
  // Gates are pure logic so a select write is seen the cycle it lands.
  // [RULE9] combinational gating
  gate_mix u_g1 (
    .i_sel(g1_en),
    .i_data(data),
    .o_gate(g1_out)
  );

  gate_mix u_g2 (
    .i_sel(g2_en),
    .i_data(data),
    .o_gate(g2_out)
  );

  gate_mix u_g3 (
    .i_sel(g3_en),
    .i_data(data),
    .o_gate(g3_out)
  );

  assign o_gates = '{g3: g3_out, g2: g2_out, g1: g1_out};
endmodule // logic_cell_gate_input_select

// ==== dv/gate_sel_props.sv ====
`timescale 1ns/1ps
module gate_sel_props (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire gate_sel_pkg::reg_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic [15:0] i_src,
  input wire logic i_d1,
  input wire logic i_d2,
  input wire gate_sel_pkg::gate_out_s o_gates,
  input wire gate_sel_pkg::data_in_s o_data
);
  import gate_sel_pkg::*;
  sel_t sh_ff [4];
  logic [7:0] rd_exp;
  logic [7:0] cand;
  logic [3:0] d4_idx;
  data_in_s exp_data;
  // Expected data inputs rebuilt from the pins, not from the outputs
  assign exp_data = '{d4: i_src[d4_idx], d3: i_src[{1'b1, sh_ff[3][2:0]}],
                      d2: i_d2, d1: i_d1};
  assign cand = {exp_data.d4, ~exp_data.d4, exp_data.d3, ~exp_data.d3,
                 exp_data.d2, ~exp_data.d2, exp_data.d1, ~exp_data.d1};
  assign rd_exp = (i_req.addr > 4'h3) ? 8'h00 :
                  sh_ff[i_req.addr[1:0]] & ((i_req.addr == 4'h3) ? 8'h77 : 8'hff);
  // Wraps past input 15 down to input 0
  assign d4_idx = 4'hc + {1'b0, sh_ff[3][6:4]};
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) sh_ff <= '{default: 8'h00};
    else if (i_req.wr && i_req.addr < 4'h4) sh_ff[i_req.addr[1:0]] <= i_req.wdata;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_rd;
    i_req.rd;
  endsequence
  a_read_back: assert property (s_rd |=> o_rdata == $past(rd_exp))
    else $error("read data mismatch");
  a_rdata_idle: assert property (!i_req.rd |=> o_rdata == 8'h00)
    else $error("read data outside read");
  a_gate1_mix: assert property (o_gates.g1 == |(sh_ff[0] & cand))
    else $error("gate 1 mismatch");
  a_gate2_mix: assert property (o_gates.g2 == |(sh_ff[1] & cand))
    else $error("gate 2 mismatch");
  a_gate3_mix: assert property (o_gates.g3 == |(sh_ff[2] & cand))
    else $error("gate 3 mismatch");
  a_d3_source: assert property (o_data.d3 == i_src[{1'b1, sh_ff[3][2:0]}])
    else $error("data 3 source mismatch");
  a_d4_source: assert property (o_data.d4 == i_src[d4_idx])
    else $error("data 4 source mismatch");
  a_d12_pass: assert property (o_data.d1 == i_d1 && o_data.d2 == i_d2)
    else $error("data 1 or 2 mismatch");
endmodule // gate_sel_props

// ==== dv/logic_cell_gate_input_select_tb.sv ====
`timescale 1ns/1ps
module logic_cell_gate_input_select_tb;
  import gate_sel_pkg::*;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  reg_req_s i_req = '0;
  logic [15:0] i_src = 16'h0000;
  logic i_d1 = 1'b0;
  logic i_d2 = 1'b0;
  logic [7:0] o_rdata;
  gate_out_s o_gates;
  data_in_s o_data;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [3:0] d;
  logic [2:0] exp_g;
  logic_cell_gate_input_select dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(i_req),
    .o_rdata(o_rdata), .i_src(i_src), .i_d1(i_d1), .i_d2(i_d2), .o_gates(o_gates),
    .o_data(o_data));
  always #2.5 i_mclk = ~i_mclk;
  task automatic summarize();
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    i_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    i_req <= '0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    i_req <= '0;
    #1 chk(o_rdata, exp);
    @(posedge i_mclk);
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    wr(4'h3, 8'h00);
    for (int g = 0; g < 3; g++) begin
      for (int b = 0; b < 8; b++) begin
        wr(g[3:0], 8'h01 << b);
        rd(g[3:0], 8'h01 << b);
        for (int p = 0; p < 16; p++) begin
          d = p[3:0];
          {i_src[12], i_src[8], i_d2, i_d1} <= d;
          #1 exp_g = 3'b000;
          exp_g[g] = b[0] ? d[b / 2] : ~d[b / 2];
          chk({5'h00, o_gates}, {5'h00, exp_g});
          @(posedge i_mclk);
        end
      end
      wr(g[3:0], 8'h00);
    end
    for (int c = 0; c < 8; c++) begin
      wr(4'h3, {1'b1, c[2:0], 1'b1, c[2:0]});
      rd(4'h3, {1'b0, c[2:0], 1'b0, c[2:0]});
      i_src <= 16'h0001 << (8 + c);
      #1 chk({6'h00, o_data.d4, o_data.d3}, 8'h01);
      @(posedge i_mclk);
      i_src <= 16'h0001 << ((c + 12) % 16);
      #1 chk({6'h00, o_data.d4, o_data.d3}, 8'h02);
      @(posedge i_mclk);
    end
    wr(4'h0, 8'h03);
    #1 chk({5'h00, o_gates}, 8'h01);
    @(posedge i_mclk);
    wr(4'h2, 8'ha5);
    wr(4'h4, 8'hff);
    rd(4'h4, 8'h00);
    rd(4'h2, 8'ha5);
    summarize();
  end
endmodule // logic_cell_gate_input_select_tb
bind logic_cell_gate_input_select gate_sel_props props_u (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_req(i_req), .o_rdata(o_rdata), .i_src(i_src), .i_d1(i_d1), .i_d2(i_d2),
  .o_gates(o_gates), .o_data(o_data));
